// ### design/pmi_top.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module pmi_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [7:0]  phy_mgmt_control;
  logic [7:0]  phy_write_data_low;
  logic [7:0]  phy_write_data_high;
  logic [4:0]  phy_register_select;
  logic [4:0]  phy_unit_select;
  logic [15:0] phy_read_word;
  logic [4:0]  mgmt_scan_status;
  logic [7:0]  int_status;
  logic [7:0]  int_mask;
  logic        wr_pend;
  logic [7:0]  wr_idx;
  logic        rd_sync1;
  logic        rd_sync2;
  logic [4:0]  div_cnt;
  logic        mdc_fall;
  logic        mdc_rise;
  pmi_pkg::pmi_state_t state;
  logic [63:0] frame;
  logic [6:0]  bit_idx;
  logic        cur_read;
  logic        cur_write;
  logic [4:0]  cur_phy;
  logic [4:0]  scan_addr;
  logic [15:0] shift_in;
  logic        done_evt;
  logic        start_wr;
  logic        start_rd;
  logic        start_scan;
  logic        start_scan_q;
  logic        we;
  logic        we_ctrl;
  logic        wr_rise;
  logic        rd_rise;
  logic [4:0]  next_scan_addr;

  // Half period of MDC in system clocks for each select code
  function automatic logic [4:0] half_div(input logic [2:0] sel);
    case (sel)
      3'h0, 3'h1: half_div = 5'h02;
      3'h2:       half_div = 5'h03;
      3'h3:       half_div = 5'h04;
      3'h4:       half_div = 5'h05;
      3'h5:       half_div = 5'h07;
      3'h6:       half_div = 5'h0A;
      3'h7:       half_div = 5'h0E;
      default:    half_div = 5'h02;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // AHB-Lite slave: zero wait state, always OKAY
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture the address phase of a write for use in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end else if (clk_en) begin
      if (hready) begin
        wr_pend <= hsel & htrans[1] & hwrite;
        wr_idx  <= haddr[9:2];
      end
    end
  end

  assign we      = wr_pend & clk_en;
  assign we_ctrl = we && wr_idx == pmi_pkg::IDX_CONTROL;
  // A command counts only on a zero-to-one change while the link is idle
  assign wr_rise = we_ctrl & hwdata[pmi_pkg::BIT_WRITE_CMD]
                   & ~phy_mgmt_control[pmi_pkg::BIT_WRITE_CMD];
  assign rd_rise = we_ctrl & hwdata[pmi_pkg::BIT_READ_CMD]
                   & ~phy_mgmt_control[pmi_pkg::BIT_READ_CMD];

  // Read data is registered during the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[9:2])
        pmi_pkg::IDX_CONTROL:    hrdata <= {24'h0, phy_mgmt_control};
        pmi_pkg::IDX_WDATA_LOW:  hrdata <= {24'h0, phy_write_data_low};
        pmi_pkg::IDX_WDATA_HIGH: hrdata <= {24'h0, phy_write_data_high};
        pmi_pkg::IDX_REG_SELECT: hrdata <= {27'h0, phy_register_select};
        pmi_pkg::IDX_UNIT_SEL:   hrdata <= {27'h0, phy_unit_select};
        pmi_pkg::IDX_READ_DATA:  hrdata <= {16'h0, phy_read_word};
        pmi_pkg::IDX_SCAN_STAT:  hrdata <= {24'h0,
                                  state == pmi_pkg::PMI_BUSY,
                                  2'h0, mgmt_scan_status};
        pmi_pkg::IDX_INT_STATUS: hrdata <= {24'h0, int_status};
        pmi_pkg::IDX_INT_MASK:   hrdata <= {24'h0, int_mask};
        default:                 hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; command bits clear themselves when their frame ends, the read bit only while scan is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_mgmt_control <= pmi_pkg::RST_CONTROL;
    end else if (clk_en) begin
      if (we_ctrl) begin
        phy_mgmt_control[5:0] <= hwdata[5:0];
        // Busy link: the edge is dropped and the bit reads back zero
        phy_mgmt_control[pmi_pkg::BIT_WRITE_CMD] <=
          phy_mgmt_control[pmi_pkg::BIT_WRITE_CMD]
          | (wr_rise & state == pmi_pkg::PMI_IDLE);
        phy_mgmt_control[pmi_pkg::BIT_READ_CMD] <=
          phy_mgmt_control[pmi_pkg::BIT_READ_CMD]
          | (rd_rise & state == pmi_pkg::PMI_IDLE);
      end
      if (done_evt && cur_write)
        phy_mgmt_control[pmi_pkg::BIT_WRITE_CMD] <= 1'b0;
      if (done_evt && cur_read && !start_scan_q)
        phy_mgmt_control[pmi_pkg::BIT_READ_CMD] <= 1'b0;
    end
  end

  // Plain data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_write_data_low  <= pmi_pkg::RST_WDATA;
      phy_write_data_high <= pmi_pkg::RST_WDATA;
      phy_register_select <= pmi_pkg::RST_SEL;
      phy_unit_select     <= pmi_pkg::RST_SEL;
      int_mask            <= 8'h00;
    end else if (we) begin
      case (wr_idx)
        pmi_pkg::IDX_WDATA_LOW:  phy_write_data_low  <= hwdata[7:0];
        pmi_pkg::IDX_WDATA_HIGH: phy_write_data_high <= hwdata[7:0];
        pmi_pkg::IDX_REG_SELECT: phy_register_select <= hwdata[4:0];
        pmi_pkg::IDX_UNIT_SEL:   phy_unit_select     <= hwdata[4:0];
        pmi_pkg::IDX_INT_MASK:   int_mask            <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status <= 8'h00;
    end else if (clk_en) begin
      if (we && wr_idx == pmi_pkg::IDX_INT_STATUS)
        int_status <= int_status & ~hwdata[7:0];
      if (done_evt)
        int_status[pmi_pkg::BIT_DONE] <= 1'b1;
    end
  end

  assign irq = |(int_status & int_mask);

  // ----------------------------------------------------------------------
  // MDIO input synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_sync1 <= 1'b0;
      rd_sync2 <= 1'b0;
    end else if (clk_en) begin
      rd_sync1 <= mdio_in;
      rd_sync2 <= rd_sync1;
    end
  end

  // ----------------------------------------------------------------------
  // MDC divider; free running so edges stay evenly spaced
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 5'h00;
      mdc     <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt >= half_div(phy_mgmt_control[2:0]) - 5'h01) begin
        div_cnt <= 5'h00;
        mdc     <= ~mdc;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  assign mdc_fall = clk_en & mdc
                    & (div_cnt >= half_div(phy_mgmt_control[2:0]) - 5'h01);
  assign mdc_rise = clk_en & ~mdc
                    & (div_cnt >= half_div(phy_mgmt_control[2:0]) - 5'h01);

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  assign start_scan_q = phy_mgmt_control[pmi_pkg::BIT_SCAN];
  // Priority at idle: pending write, then read, then scan
  assign start_wr   = state == pmi_pkg::PMI_IDLE
                      & phy_mgmt_control[pmi_pkg::BIT_WRITE_CMD];
  assign start_rd   = state == pmi_pkg::PMI_IDLE & ~start_wr
                      & phy_mgmt_control[pmi_pkg::BIT_READ_CMD];
  assign start_scan = state == pmi_pkg::PMI_IDLE & ~start_wr & ~start_rd
                      & start_scan_q;
  assign done_evt   = state == pmi_pkg::PMI_BUSY & mdc_fall
                      & bit_idx == pmi_pkg::FRAME_BITS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= pmi_pkg::PMI_IDLE;
      frame     <= 64'h0;
      bit_idx   <= 7'h00;
      cur_read  <= 1'b0;
      cur_write <= 1'b0;
      cur_phy   <= 5'h00;
      mdio_out  <= 1'b1;
      mdio_oe   <= 1'b0;
    end else if (clk_en) begin
      case (state)
        pmi_pkg::PMI_IDLE: begin
          mdio_oe <= 1'b0;
          if (start_wr || start_rd || start_scan) begin
            state     <= pmi_pkg::PMI_BUSY;
            cur_write <= start_wr;
            cur_read  <= ~start_wr;
            cur_phy   <= start_scan ? scan_addr : phy_unit_select;
            frame <= {32'hFFFF_FFFF, pmi_pkg::START_CODE,
                      start_wr ? pmi_pkg::OP_WRITE : pmi_pkg::OP_READ,
                      start_scan ? scan_addr : phy_unit_select,
                      phy_register_select, pmi_pkg::TA_WRITE,
                      phy_write_data_high, phy_write_data_low};
            // Suppressed preamble starts straight at the start code
            bit_idx <= phy_mgmt_control[pmi_pkg::BIT_PRE_SUPP]
                       ? pmi_pkg::PREAMBLE_BITS : 7'h00;
          end
        end
        pmi_pkg::PMI_BUSY: begin
          if (mdc_fall) begin
            if (bit_idx == pmi_pkg::FRAME_BITS) begin
              state    <= pmi_pkg::PMI_IDLE;
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b1;
            end else begin
              // Data changes on falling MDC, stable for the rising edge
              mdio_out <= frame[6'(7'h3F - bit_idx)];
              mdio_oe  <= cur_write | bit_idx < pmi_pkg::TA_FIRST_BIT;
              bit_idx  <= bit_idx + 7'h01;
            end
          end
        end
        default: state <= pmi_pkg::PMI_IDLE;
      endcase
    end
  end

  // Read data sampled on rising MDC during the data bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_in <= 16'h0000;
    end else if (mdc_rise && state == pmi_pkg::PMI_BUSY && cur_read
                 && bit_idx > pmi_pkg::DATA_FIRST) begin
      shift_in <= {shift_in[14:0], rd_sync2};
    end
  end

  // Completed read: word and source address are held for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_read_word    <= 16'h0000;
      mgmt_scan_status <= 5'h00;
    end else if (done_evt && cur_read) begin
      phy_read_word    <= shift_in;
      mgmt_scan_status <= cur_phy;
    end
  end

  // ----------------------------------------------------------------------
  // Scan address walk
  // ----------------------------------------------------------------------
  always_comb begin
    next_scan_addr = scan_addr;
    if (!start_scan_q) begin
      next_scan_addr = phy_unit_select;
    end else if (done_evt && cur_read) begin
      if (!phy_mgmt_control[pmi_pkg::BIT_SCAN_INC])
        next_scan_addr = phy_unit_select;
      else if (cur_phy == pmi_pkg::LAST_PHY)
        next_scan_addr = phy_unit_select;
      else
        next_scan_addr = cur_phy + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_addr <= 5'h00;
    end else if (clk_en) begin
      scan_addr <= next_scan_addr;
    end
  end

endmodule

// ### include/pmi_pkg.sv
// Overview of operation
// - A rising write-command bit, with the link idle, sends the write word to the chosen PHY and then clears itself.
// - A rising read-command bit, with the link idle, reads a PHY word into the read-data register and then clears itself unless continuous scan is set.
// - The scan-address-increment bit advances the PHY address after each scan read, only while continuous scan is set.
// - An incrementing scan starts at the unit-select value, counts to 1Fh, then wraps back to the unit-select value.
// - While continuous scan is set, read cycles follow one another with no further software command.
// - In scan mode the done flag is set each time a PHY read completes.
// - A completed scan read leaves its word in the read-data register and its PHY address in the scan status field.
// - The preamble-suppress bit omits the preamble; when clear the normal 32-bit preamble is sent.
// - The low write byte gives bits 7 to 0 and the high write byte bits 15 to 8 of one 16-bit word.
// - The write word goes out serially on MDIO during a write cycle.
// - Each cycle addresses the register from register select and the PHY from unit select, or from the scan address during a scan.
// - Control and both write-data bytes reset to zero: no command, no scan, preamble on, divide by 4.
// - Unit select is a 5-bit field choosing one of 32 PHYs.
// - Register select is a 5-bit field choosing the register inside the PHY.
package pmi_pkg;

  // ----------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL    = 8'h3B;
  localparam logic [7:0] IDX_WDATA_LOW  = 8'h3C;
  localparam logic [7:0] IDX_WDATA_HIGH = 8'h3D;
  localparam logic [7:0] IDX_REG_SELECT = 8'h3E;
  localparam logic [7:0] IDX_UNIT_SEL   = 8'h3F;
  localparam logic [7:0] IDX_READ_DATA  = 8'h50;
  localparam logic [7:0] IDX_SCAN_STAT  = 8'h51;
  localparam logic [7:0] IDX_INT_STATUS = 8'h52;
  localparam logic [7:0] IDX_INT_MASK   = 8'h53;

  // ----------------------------------------------------------------------
  // Control register fields and the done bit of the interrupt status register
  // ----------------------------------------------------------------------
  localparam int BIT_WRITE_CMD = 7;
  localparam int BIT_READ_CMD  = 6;
  localparam int BIT_SCAN_INC  = 5;
  localparam int BIT_SCAN      = 4;
  localparam int BIT_PRE_SUPP  = 3;
  localparam int BIT_DONE      = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_WDATA   = 8'h00;
  localparam logic [4:0] RST_SEL     = 5'h00;

  // ----------------------------------------------------------------------
  // Frame layout and timing counts
  // ----------------------------------------------------------------------
  localparam logic [6:0] FRAME_BITS    = 7'h40;
  localparam logic [6:0] PREAMBLE_BITS = 7'h20;
  localparam logic [6:0] TA_FIRST_BIT  = 7'h2E;
  localparam logic [6:0] DATA_FIRST    = 7'h30;
  localparam logic [4:0] LAST_PHY      = 5'h1F;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] START_CODE    = 2'h1;
  localparam logic [1:0] TA_WRITE      = 2'h2;

  typedef enum logic {PMI_IDLE, PMI_BUSY} pmi_state_t;

endpackage

// ### dv/pmi_asserts.sv
`timescale 1ns/1ns
module pmi_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        mdc,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic        irq
);
  // ------------
  // Helpers
  // ------------
  logic       mdc_q;
  logic [6:0] bits;
  logic       rd_req;

  // Read address phase accepted at this edge
  assign rd_req = hsel && htrans[1] && hready && !hwrite;

  // Bits driven in the current frame, cleared once the pin is let go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdc_q <= 1'b0;
      bits  <= 7'h00;
    end else begin
      mdc_q <= mdc;
      if (!mdio_oe) begin
        bits <= 7'h00;
      end else if (mdc_q && !mdc) begin
        bits <= bits + 7'h01;
      end
    end
  end

  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a: assert property (!hresp)
    else $error("error response seen");
  no_wait_a: assert property (hreadyout)
    else $error("wait state inserted");
  unmapped_zero_a: assert property (
    rd_req && haddr[9:2] == 8'h00 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_width_a: assert property (
    rd_req && haddr[9:2] == 8'h3B |=> hrdata[31:8] == 24'h0)
    else $error("control read has upper bits set");
  rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
  out_on_fall_a: assert property (
    $changed(mdio_out) |-> $fell(mdc))
    else $error("data out changed off the falling clock");
  oe_on_fall_a: assert property (
    $changed(mdio_oe) |-> $fell(mdc))
    else $error("output enable changed off the falling clock");
  mdc_high_a: assert property ($rose(mdc) |=> mdc)
    else $error("clock high for one cycle only");
  mdc_low_a: assert property ($fell(mdc) |=> !mdc)
    else $error("clock low for one cycle only");
  frame_len_a: assert property (
    $fell(mdio_oe) |-> bits inside {7'h0E, 7'h20, 7'h2E, 7'h40})
    else $error("driven frame length wrong");

  wr_frame_c: cover property ($fell(mdio_oe) && bits == 7'h40);
  rd_frame_c: cover property ($fell(mdio_oe) && bits == 7'h0E);
  irq_c: cover property ($rose(irq));
endmodule

bind pmi_top pmi_asserts i_chk (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mdc(mdc),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq));

// ### dv/pmi_phy_model.sv
`timescale 1ns/1ns
module pmi_phy_model (
  input  wire logic        mdc,
  input  wire logic        mdio,
  input  wire logic        drv,
  input  wire logic        slow,
  output logic             phy_out,
  output logic             phy_oe,
  output logic      [31:0] last_frame,
  output logic      [7:0]  pre_len
);
  // ------------
  // Frame capture
  // ------------
  logic [31:0] sh;
  logic [7:0]  pre;
  logic [4:0]  pa;
  logic [4:0]  ra;
  logic        rd;
  logic [15:0] word;
  int          n;

  // Answer word made from the addresses, so the bench can predict it
  assign word = {pa, ra, 6'h2A};

  initial begin
    n = 0;
    rd = 1'b0;
    pre = 8'h00;
    phy_oe = 1'b0;
    phy_out = 1'b1;
  end

  // Sample on the rising clock; a low bit while idle is the start
  always @(posedge mdc) begin
    if (n == 0) begin
      pre <= (mdio && drv) ? pre + 8'h01 : 8'h00;
      if (!mdio) begin
        pre_len <= pre;
        n <= 1;
      end
    end else begin
      sh <= {sh[30:0], mdio};
      n <= (n == 31) ? 0 : n + 1;
      if (n == 14) begin
        pa <= sh[9:5];
        ra <= sh[4:0];
        rd <= (sh[11:10] == 2'h2);
      end
      if (n == 31) last_frame <= {1'b0, sh[29:0], mdio};
    end
  end

  // Drive on the falling clock so data stands over the next rise; the
  // late answer stays off the rising hclk edges and inside the two-flop window
  always @(negedge mdc) begin
    if (slow) #30;
    phy_oe <= rd && n >= 15;
    phy_out <= (n > 15) ? word[31 - n] : 1'b0;
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ------------
  // Harness
  // ------------
  logic        hclk, hresetn, hsel, hwrite, slow;
  logic [31:0] haddr, hwdata, hrdata, last_frame;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, mdc, mdio_out, mdio_oe, irq;
  logic        phy_out, phy_oe, mdio;
  logic [7:0]  pre_len;
  int          errors, checks;

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;
  // Pull-up wins when nobody drives the line
  assign mdio = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

  pmi_top i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq));
  pmi_phy_model i_phy (.mdc(mdc), .mdio(mdio), .drv(mdio_oe),
    .slow(slow), .phy_out(phy_out), .phy_oe(phy_oe),
    .last_frame(last_frame), .pre_len(pre_len));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; holds each phase until ready is seen
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(r, e);
  endtask

  // Poll for done, check the interrupt line, then clear the flag
  task automatic wait_done(input logic e_irq);
    logic [31:0] r;
    r = 32'h0;
    while (r[0] !== 1'b1) xfer(1'b0, 8'h52, 32'h0, r);
    chk({31'h0, irq}, {31'h0, e_irq});
    wr(8'h52, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 3; i++)
      rdc(8'h3B + 8'(i), 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rdc(8'h00, 32'h0);
  endtask

  task automatic t_clk();
    int  div [8] = '{4, 4, 6, 8, 10, 14, 20, 28};
    time t0;
    for (int c = 0; c < 8; c++) begin
      wr(8'h3B, 32'(c));
      rdc(8'h3B, 32'(c));
      repeat (2) @(posedge mdc);
      t0 = $time;
      @(posedge mdc);
      chk(32'(($time - t0) / 20), 32'(div[c]));
    end
  endtask

  task automatic t_write();
    logic [31:0] e;
    wr(8'h53, 32'h1);
    wr(8'h3F, 32'h15);
    wr(8'h3E, 32'h0A);
    wr(8'h3C, 32'h3C);
    wr(8'h3D, 32'hA5);
    wr(8'h3B, 32'h84);
    wait_done(1'b1);
    e = {2'h1, 2'h1, 5'h15, 5'h0A, 2'h2, 16'hA53C};
    chk(last_frame, e);
    chk({24'h0, pre_len}, 32'h20);
    rdc(8'h3B, 32'h04);
  endtask

  task automatic t_read();
    wr(8'h53, 32'h0);
    wr(8'h3F, 32'h07);
    wr(8'h3E, 32'h13);
    wr(8'h3B, 32'h4C);
    wait_done(1'b0);
    rdc(8'h50, {16'h0, 5'h07, 5'h13, 6'h2A});
    chk({24'h0, pre_len}, 32'h0);
    rdc(8'h3B, 32'h0C);
  endtask

  // Slow partner answers while the address walks to the top and wraps;
  // then increment goes off and a write command made while busy is lost
  task automatic t_scan();
    logic [4:0]  p [4] = '{5'h1E, 5'h1F, 5'h1E, 5'h1E};
    logic [31:0] r;
    slow <= 1'b1;
    wr(8'h3F, 32'h1E);
    wr(8'h3B, 32'h3C);
    for (int k = 0; k < 4; k++) begin
      wait_done(1'b0);
      xfer(1'b0, 8'h51, 32'h0, r);
      chk({27'h0, r[4:0]}, {27'h0, p[k]});
      rdc(8'h50, {16'h0, p[k], 5'h13, 6'h2A});
      if (k == 1) begin
        wr(8'h3B, 32'h9C);
        rdc(8'h3B, 32'h1C);
      end
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    errors = 0;
    checks = 0;
    hresetn <= 1'b0;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    slow <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_clk();
    t_write();
    t_read();
    t_scan();
    end_sim();
  end

  // Whole run needs a few thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_sim();
  end
endmodule
